// ==== agc_fe_model.sv ====
// Purpose: converter front end that feeds raw samples to the correction block
// Assumes: a sample is offered, then held until it is taken
// Notes:   a released data line shows a pattern that changes every cycle
module agc_fe_model (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        en,
  input  wire logic [23:0] src_code,
  input  wire logic [23:0] gnd_code,
  input  wire logic [1:0]  cal_input_sel,
  input  wire logic        chop_invert,
  input  wire logic        raw_ready,
  output logic             raw_valid,
  output logic      [23:0] raw_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] lfsr;
  logic [23:0] idle;
  ////////////////////////////////////////
  // new sample after each take, offer held until taken
  always_ff @(posedge clk) begin
    if (srst) begin
      lfsr      <= 24'h5A3C71;
      raw_valid <= 1'b0;
      idle      <= 24'h000000;
    end else begin
      if (raw_valid && raw_ready) begin
        lfsr <= {lfsr[22:0], lfsr[23] ^ lfsr[22] ^ lfsr[21] ^ lfsr[16]};
      end
      raw_valid <= en || (raw_valid && !raw_ready);
      idle      <= raw_valid ? ~raw_data : ~idle; // released line shows the inverse
    end
  end
  // input selector: source, ground pair, or signal inverted for chopping
  always_comb begin
    if (!raw_valid) raw_data = idle;
    else if (cal_input_sel == agc_pkg::SEL_SOURCE) raw_data = src_code;
    else if (cal_input_sel == agc_pkg::SEL_GROUND) raw_data = gnd_code;
    else raw_data = chop_invert ? -lfsr : lfsr;
  end
endmodule : agc_fe_model

// ==== agc_pkg.sv ====
// Purpose: constants for the gain and offset correction block
// Assumes: 24-bit signed samples, gain word unsigned with 22 fraction bits
// Notes:   register offsets are byte addresses on a 32-bit Avalon-MM bus
package agc_pkg;
  localparam int          DW         = 24;
  localparam int          GFRAC      = 22;
  // register byte offsets
  localparam logic [4:0]  REG_CTRL   = 5'h00;
  localparam logic [4:0]  REG_OFFS   = 5'h04;
  localparam logic [4:0]  REG_GAIN   = 5'h08;
  localparam logic [4:0]  REG_STAT   = 5'h0C;
  localparam logic [4:0]  REG_FOFFS  = 5'h10;
  localparam logic [4:0]  REG_FGAIN  = 5'h14;
  localparam logic [4:0]  REG_LAST   = 5'h18;
  // control field positions
  localparam int          CTL_CHOP   = 0;
  localparam int          CTL_FACT   = 1;
  localparam int          CTL_CLK    = 2;
  localparam int          CTL_START  = 4;
  localparam int          CTL_LOSRC  = 5;
  // status field positions
  localparam int          ST_BUSY    = 0;
  localparam int          ST_DONE    = 1;
  localparam int          ST_ERR     = 2;
  // reset values
  localparam logic [23:0] GAIN_ONE   = 24'h400000;
  localparam logic [23:0] OFFS_RST   = 24'h000000;
  localparam logic [1:0]  CLK_RST    = 2'h0;
  // stored factory coefficients (plain defaults)
  localparam logic [23:0] FACT_OFFS  = 24'h000000;
  localparam logic [23:0] FACT_GAIN  = 24'h400000;
  // stored expected codes of the calibration sources (plain defaults)
  localparam logic [23:0] EXP_HI     = 24'h700000;
  localparam logic [23:0] EXP_LO     = 24'h0A0000;
  // input selector codes toward the front end
  localparam logic [1:0]  SEL_NORMAL = 2'h0;
  localparam logic [1:0]  SEL_SOURCE = 2'h1;
  localparam logic [1:0]  SEL_GROUND = 2'h2;
  // clock source codes
  localparam logic [1:0]  CLK_INTOSC = 2'h0;
  localparam logic [1:0]  CLK_XTAL   = 2'h1;
  localparam logic [1:0]  CLK_EXTIN  = 2'h2;
  localparam int          DIV_STEPS  = 24;
  typedef enum logic [1:0] {CAL_IDLE, CAL_SRC, CAL_GND, CAL_DIV} agc_cal_t;
endpackage : agc_pkg

// ==== agc_top.sv ====
// Purpose: gain and offset correction of converter samples, self-cal, chopping
// Assumes: one clock, synchronous active-high reset, Avalon-MM register slave
// Notes:   corrected words leave through a two-entry buffer with valid/ready
//
// What this block does
// (RQ1) subtract offset first, then apply gain
// (RQ2) output equals gain times (raw minus offset)
// (RQ3) host gain cal: zero offset, unity gain
// (RQ4) host offset cal: measured minus gain times input
// (RQ5) factory coefficients held and selectable
// (RQ6) self-cal measures source and ground, derives coefficients
// (RQ7) host may convert common input for offset; not offered here, only the self-cal ground step selects SEL_GROUND
// (RQ8) chopping averages difference of two conversions
// (RQ9) chopping halves the output rate
// (RQ10) clock source is selectable among three
// (RQ11) corrected result saturates, never wraps
//
// Chosen here: the register addresses and register access over Avalon-MM.
module agc_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_data,
  output logic             raw_ready,
  output logic             out_valid,
  output logic      [23:0] out_data,
  input  wire logic        out_ready,
  output logic      [1:0]  cal_input_sel,
  output logic             chop_invert,
  output logic      [1:0]  clk_src_sel
);
  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers
  function automatic logic [23:0] sat24(input logic signed [49:0] v);
    if (v > 50'sd8388607) begin
      sat24 = 24'h7FFFFF;
    end else if (v < -50'sd8388608) begin
      sat24 = 24'h800000;
    end else begin
      sat24 = v[23:0];
    end
  endfunction : sat24

  function automatic logic [23:0] correct(input logic [23:0] x,
                                          input logic [23:0] o,
                                          input logic [23:0] g);
    logic signed [24:0] d;
    logic signed [49:0] p;
    d = $signed({x[23], x}) - $signed({o[23], o});
    p = 50'(d * $signed({1'b0, g})) >>> agc_pkg::GFRAC;
    correct = sat24(p);
  endfunction : correct

  ////////////////////////////////////////////////////////////////////////////
  // registers and internal state
  logic                 chop_en;
  logic                 use_fact;
  logic                 lo_src;
  logic [23:0]          offset_coefficient;
  logic [23:0]          gain_coefficient;
  logic [23:0]          last_out;
  logic                 cal_done;
  logic                 cal_err;
  agc_pkg::agc_cal_t    cal_st;
  logic [23:0]          cal_src_raw;
  logic [23:0]          cal_div;
  logic [23:0]          cal_q;
  logic [4:0]           cal_bit;
  logic                 chop_phase;
  logic [23:0]          chop_first;
  logic [23:0]          buf_tail;
  logic [1:0]           buf_cnt;
  logic                 acc;
  logic                 wr_ok;
  logic                 start;
  logic                 take;
  logic                 push;
  logic                 pop;
  logic [23:0]          push_val;
  logic [23:0]          act_off;
  logic [23:0]          act_gain;
  logic [23:0]          chop_avg;
  logic [23:0]          trial;
  logic [1:0]           next_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // bus access decode: one wait cycle, access completes when waitrequest low
  assign acc   = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_ok = acc & avs_write;
  assign start = wr_ok & (avs_address == agc_pkg::REG_CTRL) & avs_byteenable[0]
                 & avs_writedata[agc_pkg::CTL_START] & (cal_st == agc_pkg::CAL_IDLE);

  // active coefficients: factory set or user/self-cal set
  assign act_off  = use_fact ? agc_pkg::FACT_OFFS : offset_coefficient; // RQ5
  assign act_gain = use_fact ? agc_pkg::FACT_GAIN : gain_coefficient;   // RQ5

  // stream: take a raw word, chop pairs produce one word per two takes
  assign take     = raw_valid & raw_ready;
  assign chop_avg = 24'(($signed({chop_first[23], chop_first})
                         - $signed({raw_data[23], raw_data})) >>> 1); // RQ8
  assign push     = take & (~chop_en | chop_phase); // RQ9
  assign push_val = correct(chop_en ? chop_avg : raw_data, act_off, act_gain); // RQ1 RQ2 RQ11
  assign pop      = out_valid & out_ready;
  assign next_cnt = 2'(buf_cnt + {1'b0, push} - {1'b0, pop});
  assign trial    = cal_q | (24'h800000 >> cal_bit);

  ////////////////////////////////////////////////////////////////////////////
  // waitrequest and read data
  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        case (avs_address)
          agc_pkg::REG_CTRL:  avs_readdata <= {26'h0, lo_src, 1'b0, clk_src_sel,
                                               use_fact, chop_en};
          agc_pkg::REG_OFFS:  avs_readdata <= {8'h00, offset_coefficient};
          agc_pkg::REG_GAIN:  avs_readdata <= {8'h00, gain_coefficient};
          agc_pkg::REG_STAT:  avs_readdata <= {29'h0, cal_err, cal_done,
                                               cal_st != agc_pkg::CAL_IDLE};
          agc_pkg::REG_FOFFS: avs_readdata <= {8'h00, agc_pkg::FACT_OFFS};
          agc_pkg::REG_FGAIN: avs_readdata <= {8'h00, agc_pkg::FACT_GAIN};
          agc_pkg::REG_LAST:  avs_readdata <= {8'h00, last_out};
          default:            avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // control register: chop, coefficient source, clock source, cal source
  always_ff @(posedge clk) begin
    if (srst) begin
      chop_en     <= 1'b0;
      use_fact    <= 1'b0;
      lo_src      <= 1'b0;
      clk_src_sel <= agc_pkg::CLK_RST;
    end else if (wr_ok && avs_address == agc_pkg::REG_CTRL && avs_byteenable[0]) begin
      chop_en     <= avs_writedata[agc_pkg::CTL_CHOP];
      use_fact    <= avs_writedata[agc_pkg::CTL_FACT];
      lo_src      <= avs_writedata[agc_pkg::CTL_LOSRC];
      clk_src_sel <= avs_writedata[agc_pkg::CTL_CLK +: 2]; // RQ10
    end
  end

  // coefficients: host writes, self-cal overwrites offset at its ground step and gain at its end unless cal_err is set
  always_ff @(posedge clk) begin
    if (srst) begin
      offset_coefficient <= agc_pkg::OFFS_RST;
      gain_coefficient   <= agc_pkg::GAIN_ONE;
    end else if (cal_st == agc_pkg::CAL_GND && take) begin
      offset_coefficient <= raw_data; // RQ6
    end else if (cal_st == agc_pkg::CAL_DIV && cal_bit == 5'(agc_pkg::DIV_STEPS)) begin
      if (!cal_err) begin
        gain_coefficient <= cal_q; // RQ6
      end
    end else if (wr_ok) begin
      for (int i = 0; i < 3; i++) begin
        if (avs_byteenable[i] && avs_address == agc_pkg::REG_OFFS) begin
          offset_coefficient[8*i +: 8] <= avs_writedata[8*i +: 8];
        end
        if (avs_byteenable[i] && avs_address == agc_pkg::REG_GAIN) begin
          gain_coefficient[8*i +: 8] <= avs_writedata[8*i +: 8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-calibration: source sample, ground sample, then bitwise division
  always_ff @(posedge clk) begin
    if (srst) begin
      cal_st        <= agc_pkg::CAL_IDLE;
      cal_input_sel <= agc_pkg::SEL_NORMAL;
      cal_src_raw   <= 24'h000000;
      cal_div       <= 24'h000000;
      cal_q         <= 24'h000000;
      cal_bit       <= 5'h00;
      cal_done      <= 1'b0;
      cal_err       <= 1'b0;
    end else begin
      case (cal_st)
        agc_pkg::CAL_IDLE: begin
          if (start) begin
            cal_st        <= agc_pkg::CAL_SRC;
            cal_input_sel <= agc_pkg::SEL_SOURCE; // RQ6
            cal_done      <= 1'b0;
            cal_err       <= 1'b0;
          end
        end
        agc_pkg::CAL_SRC: begin
          if (take) begin
            cal_src_raw   <= raw_data;
            cal_st        <= agc_pkg::CAL_GND;
            cal_input_sel <= agc_pkg::SEL_GROUND; // RQ6
          end
        end
        agc_pkg::CAL_GND: begin
          if (take) begin
            cal_div       <= 24'(cal_src_raw - raw_data);
            cal_err       <= $signed(cal_src_raw) <= $signed(raw_data);
            cal_q         <= 24'h000000;
            cal_bit       <= 5'h00;
            cal_st        <= agc_pkg::CAL_DIV;
            cal_input_sel <= agc_pkg::SEL_NORMAL;
          end
        end
        agc_pkg::CAL_DIV: begin
          if (cal_bit == 5'(agc_pkg::DIV_STEPS)) begin
            cal_st   <= agc_pkg::CAL_IDLE;
            cal_done <= 1'b1;
          end else begin
            // keep the trial bit while trial times measured span fits
            if (48'(trial * cal_div) <= 48'({lo_src ? agc_pkg::EXP_LO : agc_pkg::EXP_HI,
                                              22'h0})) begin
              cal_q <= trial; // RQ6
            end
            cal_bit <= 5'(cal_bit + 5'h01);
          end
        end
        default: cal_st <= agc_pkg::CAL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chopping phase: first conversion held, second one completes the pair
  always_ff @(posedge clk) begin
    if (srst || !chop_en) begin
      chop_phase  <= 1'b0;
      chop_invert <= 1'b0;
      chop_first  <= 24'h000000;
    end else if (take) begin
      chop_phase  <= ~chop_phase; // RQ8
      chop_invert <= ~chop_phase;
      if (!chop_phase) begin
        chop_first <= raw_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry output buffer, head word is the output register itself
  always_ff @(posedge clk) begin
    if (srst) begin
      buf_cnt   <= 2'h0;
      out_valid <= 1'b0;
      raw_ready <= 1'b0;
      out_data  <= 24'h000000;
      buf_tail  <= 24'h000000;
      last_out  <= 24'h000000;
    end else begin
      buf_cnt   <= next_cnt;
      out_valid <= next_cnt != 2'h0;
      raw_ready <= next_cnt != 2'h2; // stalls the source when full
      if (push) begin
        last_out <= push_val;
      end
      if (buf_cnt == 2'h2 && pop) begin
        out_data <= buf_tail;
      end else if (push && (buf_cnt == 2'h0 || pop)) begin
        out_data <= push_val;
      end
      if (push && (buf_cnt == 2'h2 || (buf_cnt == 2'h1 && !pop))) begin
        buf_tail <= push_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  offset_first_a: assert property (take && !chop_en && act_gain == agc_pkg::GAIN_ONE // RQ1
    |-> push_val == sat24(50'($signed({raw_data[23], raw_data})
                              - $signed({act_off[23], act_off}))))
    else $error("offset not applied before unity gain");
  identity_pass_a: assert property (take && !chop_en && act_off == 24'h0 // RQ2
    && act_gain == agc_pkg::GAIN_ONE |-> push && push_val == raw_data)
    else $error("zero offset and unity gain changed data");
  factory_coef_a: assert property (use_fact && take && !chop_en // RQ5
    |-> push && push_val == correct(raw_data, agc_pkg::FACT_OFFS, agc_pkg::FACT_GAIN))
    else $error("factory coefficients not in use");
  cal_ground_a: assert property (cal_st == agc_pkg::CAL_GND && take // RQ6
    |=> offset_coefficient == $past(raw_data) && cal_st == agc_pkg::CAL_DIV
    ##[25:25] cal_st == agc_pkg::CAL_IDLE && cal_done)
    else $error("self-cal ground step or division timing wrong");
  chop_avg_a: assert property (take && chop_en && chop_phase && act_off == 24'h0 // RQ8
    && act_gain == agc_pkg::GAIN_ONE |-> push && push_val == chop_avg)
    else $error("chopped output is not half the difference");
  chop_rate_a: assert property (take && chop_en && !chop_phase // RQ9
    |-> !push ##1 chop_phase)
    else $error("chopping produced a word on the first conversion");
  clock_select_a: assert property (wr_ok && avs_address == agc_pkg::REG_CTRL // RQ10
    && avs_byteenable[0] |=> clk_src_sel == $past(avs_writedata[3:2]))
    else $error("clock source not taken from control write");
  saturate_a: assert property (take && !chop_en && act_gain == agc_pkg::GAIN_ONE // RQ11
    && $signed(raw_data) > 0 && $signed(act_off) < 0 |-> !push_val[23])
    else $error("corrected result wrapped");
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest not one cycle");

  chop_pair_c: cover property (take && chop_en && chop_phase);
  cal_done_c:  cover property (cal_st == agc_pkg::CAL_DIV ##[1:30] cal_done);
  buf_full_c:  cover property (buf_cnt == 2'h2 && !raw_ready);
  bus_read_c:  cover property (avs_read && !avs_waitrequest);
endmodule : agc_top

// ==== tb_adc_gain_offset_correction.sv ====
// Purpose: self-checking bench of the correction block
// Assumes: front end model on the raw side, random stalls on the output side
// Notes:   expected words come from the bench's own correction function
module tb_adc_gain_offset_correction;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, srst, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        raw_valid, raw_ready, out_valid, out_ready, chop_invert, en, hold;
  logic [23:0] raw_data, out_data, src, gnd, eo, eg, first, lastexp;
  logic [1:0]  cal_input_sel, clk_src_sel;
  logic [63:0] pat;
  logic [23:0] q[$];
  logic        chk, chop, half;
  int          failures, tests_run, takes;
  agc_top i_dut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .raw_valid(raw_valid),
    .raw_data(raw_data), .raw_ready(raw_ready), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .cal_input_sel(cal_input_sel), .chop_invert(chop_invert),
    .clk_src_sel(clk_src_sel));
  agc_fe_model i_fe (.clk(clk), .srst(srst), .en(en), .src_code(src), .gnd_code(gnd),
    .cal_input_sel(cal_input_sel), .chop_invert(chop_invert), .raw_ready(raw_ready),
    .raw_valid(raw_valid), .raw_data(raw_data));
  ////////////////////////////////////////
  // clock and receiver stalls
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    pat       <= {pat[0], pat[63:1]};
    out_ready <= !hold && (pat[0] || pat[1]);
  end
  ////////////////////////////////////////
  // offset first, then gain, then saturation
  function automatic logic [23:0] corr(input longint x);
    longint p;
    p = (longint'(eg) * (x - longint'($signed(eo)))) >>> 22;
    if (p > 8388607) p = 8388607;
    if (p < -8388608) p = -8388608;
    return p[23:0];
  endfunction : corr
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic tmo;
    failures++;
    tally_and_finish();
  endtask : tmo
  // scoreboard: expected word per take, chop pairs give half the difference
  always @(posedge clk) begin
    if (!srst && raw_valid && raw_ready) takes++;
    if (!srst && raw_valid && raw_ready && chk) begin
      if (!chop) q.push_back(corr($signed(raw_data)));
      else if (!half) begin
        first = raw_data;
        half  = 1'b1;
      end else begin
        q.push_back(corr((longint'($signed(first)) - longint'($signed(raw_data))) >>> 1));
        half = 1'b0;
      end
    end
    if (!srst && out_valid && out_ready && chk) begin
      if (q.size() == 0) cmp(32'h1, 32'h0);
      else begin
        lastexp = q.pop_front();
        cmp(out_data, lastexp);
      end
    end
  end
  ////////////////////////////////////////
  // register bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) tmo();
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    cmp(r, e);
  endtask : rdc
  task automatic drain;
    int k;
    for (k = 0; k < 300 && (q.size() != 0 || out_valid || raw_valid); k++) @(posedge clk);
    if (k >= 300) tmo();
  endtask : drain
  // one stream run of twenty takes under the given coefficients
  task automatic run(input logic [23:0] g, input logic [23:0] o, input logic [7:0] c);
    int n;
    wr(agc_pkg::REG_OFFS, {8'h00, o});
    wr(agc_pkg::REG_GAIN, {8'h00, g});
    rdc(agc_pkg::REG_GAIN, {8'h00, g});
    wr(agc_pkg::REG_CTRL, {24'h000000, c});
    eg   = c[agc_pkg::CTL_FACT] ? agc_pkg::FACT_GAIN : g;
    eo   = c[agc_pkg::CTL_FACT] ? agc_pkg::FACT_OFFS : o;
    chop = c[agc_pkg::CTL_CHOP];
    half = 1'b0;
    chk  = 1'b1;
    n    = takes + 20;
    en  <= 1'b1;
    for (int k = 0; k < 400 && takes < n; k++) @(posedge clk);
    if (takes < n) tmo();
    en <= 1'b0;
    drain();
    chk = 1'b0;
    rdc(agc_pkg::REG_LAST, {8'h00, lastexp});
  endtask : run
  // self-calibration against a source code and a ground code
  task automatic cal(input logic lo, input logic [23:0] s, input logic [23:0] z);
    logic [31:0] r;
    longint      x;
    int          k;
    logic [31:0] g0;
    src = s;
    gnd = z;
    bus(1'b0, agc_pkg::REG_GAIN, 32'h0, g0);
    en <= 1'b1;
    wr(agc_pkg::REG_CTRL, 32'h10 | (32'(lo) << agc_pkg::CTL_LOSRC));
    for (k = 0; k < 40; k++) begin
      bus(1'b0, agc_pkg::REG_STAT, 32'h0, r);
      if (!r[agc_pkg::ST_BUSY]) break;
    end
    if (k >= 40) tmo();
    en <= 1'b0;
    drain();
    cmp(r[agc_pkg::ST_ERR], $signed(s) <= $signed(z));
    cmp(r[agc_pkg::ST_DONE], 1'b1);
    // a refused calibration leaves the gain as it was before the start
    r = g0;
    x = longint'(lo ? agc_pkg::EXP_LO : agc_pkg::EXP_HI) << 22;
    if ($signed(s) > $signed(z)) begin
      rdc(agc_pkg::REG_OFFS, {8'h00, z});
      x = x / (longint'($signed(s)) - longint'($signed(z)));
      r = {8'h00, x[23:0]};
    end
    rdc(agc_pkg::REG_GAIN, r);
  endtask : cal
  ////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; en = 1'b0; hold = 1'b0;
    src = 24'h0; gnd = 24'h0; chk = 1'b0; chop = 1'b0; half = 1'b0; pat = 64'h0;
    failures = 0; tests_run = 0; takes = 0; lastexp = 24'h0; out_ready = 1'b0;
    void'($urandom(75));
    pat = {$urandom, $urandom};
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc(agc_pkg::REG_GAIN, {8'h00, agc_pkg::GAIN_ONE});
    rdc(agc_pkg::REG_OFFS, {8'h00, agc_pkg::OFFS_RST});
    rdc(agc_pkg::REG_FOFFS, {8'h00, agc_pkg::FACT_OFFS});
    rdc(agc_pkg::REG_FGAIN, {8'h00, agc_pkg::FACT_GAIN});
    rdc(5'h1C, 32'h0);
    for (int c = 0; c < 3; c++) begin
      wr(agc_pkg::REG_CTRL, 32'(c) << agc_pkg::CTL_CLK);
      #1;
      cmp(clk_src_sel, c);
    end
    run(agc_pkg::GAIN_ONE, 24'h000000, 8'h00);
    // host takes the last measured word of the previous run, an LFSR input, as offset
    run(agc_pkg::GAIN_ONE, lastexp, 8'h00);
    run(24'($urandom % 32'h800000), 24'($urandom), 8'h01);
    run(24'h7FFFFF, 24'h800000, 8'h00);
    run(agc_pkg::GAIN_ONE, 24'h800000, 8'h00);
    run(agc_pkg::GAIN_ONE, 24'h000000, 8'h01);
    run(24'($urandom % 32'h800000), 24'($urandom), 8'h02);
    run(24'($urandom % 32'h800000), 24'($urandom), 8'h01);
    run(24'($urandom % 32'h800000), 24'($urandom), 8'h00);
    hold = 1'b1;
    chk  = 1'b1;
    en  <= 1'b1;
    for (int k = 0; k < 50 && raw_ready !== 1'b0; k++) @(posedge clk);
    cmp(raw_ready, 1'b0);
    cmp(out_valid, 1'b1);
    hold = 1'b0;
    en  <= 1'b0;
    drain();
    chk = 1'b0;
    cal(1'b0, 24'h600000, 24'h010000);
    cal(1'b1, 24'h080000, 24'hFF0000);
    cal(1'b0, 24'h020000, 24'h020000);
    run(24'($urandom % 32'h800000), 24'($urandom), 8'h00);
    tally_and_finish();
  end
endmodule : tb_adc_gain_offset_correction
